//--- hw/p2fc_pkg.sv
// Package for the port-2 flow-control register block.
// Assumes a 32-bit memory-mapped system register port on the system clock.
package p2fc_pkg;
  localparam logic [8:0] P2FC_REG_OFFSET = 9'h1a4;
  localparam int P2FC_ADDR_W = 9;
  localparam int P2FC_DATA_W = 32;
  localparam int P2FC_BIT_BP = 6;
  localparam int P2FC_BIT_DUP = 5;
  localparam int P2FC_BIT_CRX = 4;
  localparam int P2FC_BIT_CTX = 3;
  localparam int P2FC_BIT_RX = 2;
  localparam int P2FC_BIT_TX = 1;
  localparam int P2FC_BIT_SEL = 0;
  localparam int P2FC_FIELD_W = 7;
  localparam logic [31:0] P2FC_ZERO = 32'h0000_0000;
  // Auto-negotiation pause resolution states
  typedef enum logic [2:0] {
    P2FC_ST_FORCED = 3'h1,
    P2FC_ST_NEGOT = 3'h2,
    P2FC_ST_HALF = 3'h4
  } p2fc_mode_t;
endpackage

//--- hw/p2fc_resolve.sv
// Resolves the pause settings actually in force on port 2.
// Assumes all inputs are synchronous to mclk_i.
`timescale 1ns/100ps
module p2fc_resolve (
  input wire logic sel_i,
  input wire logic rx_en_i,
  input wire logic tx_en_i,
  input wire logic an_enable_i,
  input wire logic an_done_i,
  input wire logic an_rx_i,
  input wire logic an_tx_i,
  input wire logic half_i,
  output logic rx_now_o,
  output logic tx_now_o,
  output p2fc_pkg::p2fc_mode_t mode_o
);
  import p2fc_pkg::*;

  // Pick a source for pause settings; half duplex never uses pause
  always_comb begin
    if (half_i) begin
      mode_o = P2FC_ST_HALF;
    end else if (!sel_i && an_enable_i) begin
      mode_o = P2FC_ST_NEGOT;
    end else begin
      mode_o = P2FC_ST_FORCED;
    end
  end

  // Result of negotiation counts only once negotiation has finished
  always_comb begin
    unique case (mode_o)
      P2FC_ST_HALF: begin
        rx_now_o = 1'b0;
        tx_now_o = 1'b0;
      end
      P2FC_ST_NEGOT: begin
        rx_now_o = an_done_i & an_rx_i;
        tx_now_o = an_done_i & an_tx_i;
      end
      P2FC_ST_FORCED: begin
        rx_now_o = rx_en_i;
        tx_now_o = tx_en_i;
      end
      default: begin
        rx_now_o = 1'b0;
        tx_now_o = 1'b0;
      end
    endcase
  end
endmodule

//--- hw/p2fc_top.sv
// Port-2 flow-control configuration and status register.
// Assumes a single-cycle register port; straps and link status come from pins.
`timescale 1ns/100ps
module p2fc_top (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [p2fc_pkg::P2FC_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [p2fc_pkg::P2FC_DATA_W-1:0] reg_wdata_i,
  input wire logic port2_backpressure_pin_default_i,
  input wire logic port2_pause_pin_default_i,
  input wire logic port2_select_pin_default_i,
  input wire logic strap_reload_i,
  input wire logic an_enable_i,
  input wire logic an_done_i,
  input wire logic an_rx_i,
  input wire logic an_tx_i,
  input wire logic half_duplex_i,
  output logic [p2fc_pkg::P2FC_DATA_W-1:0] reg_rdata_o,
  output logic port2_backpressure_en_o,
  output logic port2_pause_rx_now_o,
  output logic port2_pause_tx_now_o,
  output logic port2_duplex_now_o
);
  import p2fc_pkg::*;

  logic rst_meta_b, rst_b;
  logic [2:0] strap_m, strap_s;
  logic [5:0] lnk_m, lnk_s;
  logic loaded;
  logic port2_backpressure_en, port2_pause_rx_en, port2_pause_tx_en, port2_manual_select;
  logic rx_now, tx_now;
  logic [P2FC_FIELD_W-1:0] field;

  function automatic logic hit(input logic [P2FC_ADDR_W-1:0] a);
    return a == P2FC_REG_OFFSET;
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_b <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_b <= rst_meta_b;
    end
  end

  // Strap synchroniser keeps sampling through reset so pin levels are ready at release
  // No reset on purpose: clearing it would load zeros as the defaults
  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      strap_m <= {port2_backpressure_pin_default_i, port2_pause_pin_default_i,
                  port2_select_pin_default_i};
      strap_s <= strap_m;
    end
  end

  // Link synchroniser; first stage feeds only the second
  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      lnk_m <= 6'h00;
      lnk_s <= 6'h00;
    end else if (ce_i) begin
      lnk_m <= {strap_reload_i, an_enable_i, an_done_i, an_rx_i, an_tx_i, half_duplex_i};
      lnk_s <= lnk_m;
    end
  end

  // Writable fields: straps load after reset release, loader reload wins over write
  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      loaded <= 1'b0;
      port2_backpressure_en <= 1'b0;
      port2_pause_rx_en <= 1'b0;
      port2_pause_tx_en <= 1'b0;
      port2_manual_select <= 1'b0;
    end else if (ce_i) begin
      if (!loaded || lnk_s[5]) begin
        loaded <= 1'b1;
        port2_backpressure_en <= strap_s[2];
        port2_pause_rx_en <= strap_s[1];
        port2_pause_tx_en <= strap_s[1];
        port2_manual_select <= strap_s[0];
      end else if (reg_wr_i && hit(reg_addr_i)) begin
        // Only bits 6, 2, 1 and 0 land; RO and reserved bits dropped, no PHY side effect
        port2_backpressure_en <= reg_wdata_i[P2FC_BIT_BP];
        port2_pause_rx_en <= reg_wdata_i[P2FC_BIT_RX];
        port2_pause_tx_en <= reg_wdata_i[P2FC_BIT_TX];
        port2_manual_select <= reg_wdata_i[P2FC_BIT_SEL];
      end
    end
  end

  p2fc_resolve u_resolve (
    .sel_i(port2_manual_select),
    .rx_en_i(port2_pause_rx_en),
    .tx_en_i(port2_pause_tx_en),
    .an_enable_i(lnk_s[4]),
    .an_done_i(lnk_s[3]),
    .an_rx_i(lnk_s[2]),
    .an_tx_i(lnk_s[1]),
    .half_i(lnk_s[0]),
    .rx_now_o(rx_now),
    .tx_now_o(tx_now),
    .mode_o()
  );

  // Status follows straps and link, so its default mixes several straps
  always_comb begin
    field = '0;
    field[P2FC_BIT_BP] = port2_backpressure_en;
    field[P2FC_BIT_DUP] = lnk_s[0];
    field[P2FC_BIT_CRX] = rx_now;
    field[P2FC_BIT_CTX] = tx_now;
    field[P2FC_BIT_RX] = port2_pause_rx_en;
    field[P2FC_BIT_TX] = port2_pause_tx_en;
    field[P2FC_BIT_SEL] = port2_manual_select;
  end

  // Registered read data and control outputs
  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_o <= P2FC_ZERO;
      port2_backpressure_en_o <= 1'b0;
      port2_pause_rx_now_o <= 1'b0;
      port2_pause_tx_now_o <= 1'b0;
      port2_duplex_now_o <= 1'b0;
    end else if (ce_i) begin
      if (reg_rd_i && hit(reg_addr_i)) begin
        reg_rdata_o <= {{(P2FC_DATA_W-P2FC_FIELD_W){1'b0}}, field};
      end else if (reg_rd_i) begin
        reg_rdata_o <= P2FC_ZERO;
      end
      port2_backpressure_en_o <= port2_backpressure_en & lnk_s[0];
      port2_pause_rx_now_o <= rx_now;
      port2_pause_tx_now_o <= tx_now;
      port2_duplex_now_o <= lnk_s[0];
    end
  end

  // Write and readback checks
  bp_follow_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    ce_i && $past(ce_i) && loaded && !lnk_s[5] && reg_wr_i && hit(reg_addr_i)
    |=> port2_backpressure_en == $past(reg_wdata_i[P2FC_BIT_BP]))
    else $error("backpressure enable not written");
  dup_read_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    ce_i && reg_rd_i && hit(reg_addr_i) |=> reg_rdata_o[P2FC_BIT_DUP] == $past(lnk_s[0]))
    else $error("duplex readback wrong");
  rx_now_read_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    ce_i && reg_rd_i && hit(reg_addr_i) |=> reg_rdata_o[P2FC_BIT_CRX] == $past(rx_now))
    else $error("receive status readback wrong");
  tx_now_read_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    ce_i && reg_rd_i && hit(reg_addr_i) |=> reg_rdata_o[P2FC_BIT_CTX] == $past(tx_now))
    else $error("transmit status readback wrong");
  rd_unmapped_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    ce_i && reg_rd_i && !hit(reg_addr_i) |=> reg_rdata_o == P2FC_ZERO)
    else $error("unmapped read not zero");
  resv_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    reg_rdata_o[P2FC_DATA_W-1:P2FC_FIELD_W] == '0)
    else $error("reserved bits nonzero");

  // Source selection checks on the resolved pause settings
  negot_use_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    !port2_manual_select && lnk_s[4] && !lnk_s[0] |-> rx_now == (lnk_s[3] & lnk_s[2]))
    else $error("negotiated receive not used");
  tx_negot_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    !port2_manual_select && lnk_s[4] && !lnk_s[0] |-> tx_now == (lnk_s[3] & lnk_s[1]))
    else $error("negotiated transmit not used");
  manual_use_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    (port2_manual_select || !lnk_s[4]) && !lnk_s[0] |-> tx_now == port2_pause_tx_en)
    else $error("manual transmit not used");
  rx_manual_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    (port2_manual_select || !lnk_s[4]) && !lnk_s[0] |-> rx_now == port2_pause_rx_en)
    else $error("manual receive not used");
  half_block_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    lnk_s[0] |-> !rx_now && !tx_now)
    else $error("pause active in half duplex");

  // Field loading: straps first, reload later, nothing else without a write
  strap_first_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    ce_i && rst_b && !loaded
    |=> port2_backpressure_en == $past(strap_s[2]) && port2_pause_rx_en == $past(strap_s[1]))
    else $error("strap defaults not loaded");
  strap_load_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    ce_i && lnk_s[5] |=> port2_manual_select == $past(strap_s[0]))
    else $error("strap reload not applied");
  wr_refused_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    ce_i && loaded && !lnk_s[5] && !(reg_wr_i && hit(reg_addr_i))
    |=> $stable(port2_pause_rx_en) && $stable(port2_manual_select))
    else $error("field changed without write");

  // Output registers follow the internal state one cycle behind
  dup_out_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    ce_i |=> port2_duplex_now_o == $past(lnk_s[0]))
    else $error("duplex output wrong");
  bp_out_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    ce_i |=> port2_backpressure_en_o == ($past(port2_backpressure_en) & $past(lnk_s[0])))
    else $error("backpressure output wrong");
  crx_out_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    ce_i |=> port2_pause_rx_now_o == $past(rx_now))
    else $error("receive pause output wrong");
  ctx_out_a: assert property (@(posedge mclk_i) disable iff (!rst_b)
    ce_i |=> port2_pause_tx_now_o == $past(tx_now))
    else $error("transmit pause output wrong");
endmodule

//--- sim/tb_port2_flow_control_config.sv
// Self-checking bench for the port-2 flow-control register.
// Assumes the register top alone; bench drives ports at falling edges.
`timescale 1ns/100ps
module tb_port2_flow_control_config;
  import p2fc_pkg::*;
  logic mclk_i = 0, rst_b_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic [8:0] reg_addr_i = 9'h000;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
  logic bp_pin = 1, pause_pin = 1, sel_pin = 1, reload = 0;
  logic an_en = 0, an_done = 0, an_rx = 0, an_tx = 0, half = 0;
  logic bp_o, rx_o, tx_o, dup_o, rd_seen = 0;
  logic [31:0] exp_q[$];
  int n_errors = 0, checks_done = 0;
  integer seed = 32'hf634;
  p2fc_top i_p2fc_top (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .port2_backpressure_pin_default_i(bp_pin),
    .port2_pause_pin_default_i(pause_pin), .port2_select_pin_default_i(sel_pin),
    .strap_reload_i(reload), .an_enable_i(an_en), .an_done_i(an_done), .an_rx_i(an_rx),
    .an_tx_i(an_tx), .half_duplex_i(half), .reg_rdata_o(reg_rdata_o),
    .port2_backpressure_en_o(bp_o), .port2_pause_rx_now_o(rx_o),
    .port2_pause_tx_now_o(tx_o), .port2_duplex_now_o(dup_o));
  always #10 mclk_i = ~mclk_i;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle();
    repeat (5) @(negedge mclk_i);
  endtask
  // Write strobe is one cycle; status needs a few cycles to follow
  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1;
    @(negedge mclk_i);
    reg_wr_i = 0;
    settle();
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_rd_i = 1;
    exp_q.push_back(e);
    @(negedge mclk_i);
    reg_rd_i = 0;
    repeat (2) @(negedge mclk_i);
  endtask
  // Read data shows after the taking edge and stands until the next read
  always @(posedge mclk_i) rd_seen <= ce_i & reg_rd_i;
  always @(negedge mclk_i) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("Error rdata expected none seen %h", reg_rdata_o);
      end else begin
        chk("rdata", exp_q.pop_front(), reg_rdata_o);
      end
    end
  end
  task automatic give_verdict();
    // A note left in the queue means a read answer never appeared
    if (exp_q.size() != 0) begin
      n_errors++;
    end
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog sized well above the planned run
  initial begin
    #60000;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (5) @(negedge mclk_i);
    rst_b_i = 1;
    repeat (6) @(negedge mclk_i);
    rd(P2FC_REG_OFFSET, 32'h5f);
    chk("bp_out", 32'h0, {31'h0, bp_o});
    $display("test defaults done");
    // Manual, negotiation off: status follows enable bits
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(P2FC_REG_OFFSET, d);
      rd(P2FC_REG_OFFSET, (d & 32'h47) | {27'h0, d[2:1], 3'h0});
      chk("rx_out", {31'h0, d[2]}, {31'h0, rx_o});
      chk("tx_out", {31'h0, d[1]}, {31'h0, tx_o});
    end
    $display("test manual done");
    an_en = 1;
    an_done = 1;
    an_rx = 1;
    wr(P2FC_REG_OFFSET, 32'h06);
    rd(P2FC_REG_OFFSET, 32'h16);
    an_rx = 0;
    an_tx = 1;
    wr(P2FC_REG_OFFSET, 32'h00);
    rd(P2FC_REG_OFFSET, 32'h08);
    // Negotiation not finished: pause stays off
    an_done = 0;
    settle();
    rd(P2FC_REG_OFFSET, 32'h00);
    chk("tx_out", 32'h0, {31'h0, tx_o});
    wr(P2FC_REG_OFFSET, 32'h05);
    rd(P2FC_REG_OFFSET, 32'h15);
    $display("test negotiated done");
    an_en = 0;
    half = 1;
    wr(P2FC_REG_OFFSET, 32'h47);
    rd(P2FC_REG_OFFSET, 32'h67);
    chk("bp_out", 32'h1, {31'h0, bp_o});
    chk("dup_out", 32'h1, {31'h0, dup_o});
    wr(P2FC_REG_OFFSET, 32'h07);
    rd(P2FC_REG_OFFSET, 32'h27);
    chk("bp_out", 32'h0, {31'h0, bp_o});
    $display("test half duplex done");
    // Neighbouring offsets must neither read back nor disturb the register
    wr(9'h1a8, 32'hffff_ffff);
    rd(9'h1a0, P2FC_ZERO);
    rd(P2FC_REG_OFFSET, 32'h27);
    $display("test unmapped done");
    half = 0;
    bp_pin = 0;
    pause_pin = 0;
    reload = 1;
    repeat (6) @(negedge mclk_i);
    reload = 0;
    settle();
    rd(P2FC_REG_OFFSET, 32'h01);
    $display("test reload done");
    // Clock enable low: a write must not land
    ce_i = 0;
    wr(P2FC_REG_OFFSET, 32'h00);
    ce_i = 1;
    rd(P2FC_REG_OFFSET, 32'h01);
    $display("test clock enable done");
    // Second reset with other strap levels
    bp_pin = 1;
    sel_pin = 0;
    rst_b_i = 0;
    repeat (2) @(negedge mclk_i);
    rst_b_i = 1;
    repeat (6) @(negedge mclk_i);
    rd(P2FC_REG_OFFSET, 32'h40);
    chk("dup_out", 32'h0, {31'h0, dup_o});
    $display("test second reset done");
    give_verdict();
  end
endmodule
